// ### rtl/nap_datapath.sv
// Four-bit execution datapath: accumulator, carry, pointers, table fetch.
// Assumes synchronous ROM that answers in the cycle rom_rd is high, and RAM
// that reads combinationally from data_pointer and writes when ram_wr.we is high.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nap_datapath
  import nap_pkg::*;
(
  // Clock, reset and enable
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  input  wire logic               ce,
  // Instruction bytes from the sequencer
  input  wire logic               instr_valid,
  input  wire logic [7:0]         instr_byte,
  output logic                    busy,
  // Program ROM
  output logic                    rom_rd,
  output logic [ROM_AW-1:0]       rom_addr,
  input  wire logic [7:0]         rom_data,
  input  wire logic [PAGE_W-1:0]  current_page,
  // Data RAM
  output nap_ptr_t                data_pointer,
  output nap_ram_wr_t             ram_wr,
  input  wire logic [3:0]         ram_rdata,
  // Status from the halt and time-base logic
  input  wire logic [3:0]         wake_cause_status,
  input  wire logic [3:0]         half_second_status,
  output logic                    wake_cause_clr,
  output logic                    half_sec_clr,
  output logic                    timer_wake_enable,
  // Visible state
  output logic [3:0]              work_reg,
  output logic                    carry_flag,
  output logic [3:0]              temp_latch,
  output nap_ptr_t                saved_pointer
);

  nap_state_t  state;
  logic [2:0]  imm_fn;
  logic        go;
  logic        imm_go;
  logic [3:0]  mem_val;
  nap_alu_t    alu_res;
  logic [3:0]  next_work;
  logic        next_cf;
  nap_ptr_t    next_dp;
  nap_ptr_t    next_saved;
  logic        next_mem_we;
  logic [3:0]  next_mem_data;

  // Four-bit arithmetic; a carry out of bit 3 or no borrow sets carry.
  function automatic nap_alu_t nap_alu(input logic [2:0] fn,
                                       input logic [3:0] a,
                                       input logic [3:0] b,
                                       input logic       cf);
    logic [4:0] s;
    nap_alu_t   r;
    s = 5'h00;
    r = '0;
    unique case (fn)
      FN_ADC: s = {1'b0, a} + {1'b0, b} + {4'h0, cf};
      FN_SBC: s = {1'b0, a} - {1'b0, b} - {4'h0, cf};
      FN_ADD,
      FN_ADN: s = {1'b0, a} + {1'b0, b};
      FN_SUB: s = {1'b0, a} + {1'b0, ~b} + 5'h01;
      FN_AND: s = {1'b0, a & b};
      FN_XOR: s = {1'b0, a ^ b};
      FN_OR:  s = {1'b0, a | b};
    endcase
    r.val = s[3:0];
    // Only four of the five add and subtract forms touch carry; ADN leaves it.
    r.upd = (fn == FN_ADC) || (fn == FN_SBC) ||
            (fn == FN_ADD) || (fn == FN_SUB);
    // The borrow form counts down, so its carry is the inverted borrow.
    r.cf  = (fn == FN_SBC) ? ~s[4] : s[4];
    return r;
  endfunction

  assign go     = ce && instr_valid && (state == NAP_EXEC);
  assign imm_go = ce && instr_valid && (state == NAP_IMM);

  // A write still in flight to the same word is forwarded, since the RAM
  // only sees it one cycle after the instruction that made it.
  assign mem_val = (ram_wr.we && (ram_wr.addr == data_pointer)) ?
                   ram_wr.data : ram_rdata;

  always_comb begin
    if (imm_go) begin
      alu_res = nap_alu(imm_fn, work_reg, instr_byte[3:0], carry_flag);
    end else begin
      alu_res = nap_alu(instr_byte[2:0], work_reg, mem_val, carry_flag);
    end
  end

  always_comb begin
    next_work     = work_reg;
    next_cf       = carry_flag;
    next_dp       = data_pointer;
    next_saved    = saved_pointer;
    next_mem_we   = 1'b0;
    next_mem_data = mem_val;
    if (imm_go) begin
      next_work = alu_res.val;
      if (alu_res.upd) begin
        next_cf = alu_res.cf;
      end
    end else if (go) begin
      if (instr_byte[7:4] == GRP_MEM_ALU) begin
        next_work = alu_res.val;
        if (alu_res.upd) begin
          next_cf = alu_res.cf;
        end
        next_mem_we   = instr_byte[WRITE_BACK_BIT];
        next_mem_data = alu_res.val;
      end else if (instr_byte[7:4] == GRP_LOAD_LOW) begin
        next_dp.low = instr_byte[3:0];
      end else if (instr_byte[7:4] == GRP_LOAD_HIGH) begin
        next_dp.high = instr_byte[3:0];
      end else begin
        unique case (instr_byte)
          OP_SHR0, OP_SHR1: next_work = {instr_byte[0], work_reg[3:1]};
          OP_SHL0, OP_SHL1: next_work = {work_reg[2:0], instr_byte[0]};
          OP_MEM_INC: begin
            next_work     = mem_val + 4'h1;
            next_mem_we   = 1'b1;
            next_mem_data = mem_val + 4'h1;
          end
          OP_MEM_DEC: begin
            next_work     = mem_val - 4'h1;
            next_mem_we   = 1'b1;
            next_mem_data = mem_val - 4'h1;
          end
          OP_STORE_TEMP: begin
            next_mem_we   = 1'b1;
            next_mem_data = temp_latch;
          end
          OP_PUT_LOW:   next_dp.low  = work_reg;
          OP_PUT_HIGH:  next_dp.high = work_reg;
          OP_GET_LOW:   next_work    = data_pointer.low;
          OP_GET_HIGH:  next_work    = data_pointer.high;
          OP_SWAP_LOW: begin
            next_dp.low    = saved_pointer.low;
            next_saved.low = data_pointer.low;
          end
          OP_SWAP_HIGH: begin
            next_dp.high    = saved_pointer.high;
            next_saved.high = data_pointer.high;
          end
          OP_STEP_UP_L: next_dp.low  = data_pointer.low + 4'h1;
          OP_STEP_DN_L: next_dp.low  = data_pointer.low - 4'h1;
          OP_STEP_UP_H: next_dp.high = data_pointer.high + 4'h1;
          OP_STEP_DN_H: next_dp.high = data_pointer.high - 4'h1;
          OP_HALT_CAUSE: next_work = wake_cause_status;
          OP_HALF_SEC:   next_work = half_second_status;
          OP_CLR_CARRY:  next_cf   = 1'b0;
          OP_SET_CARRY:  next_cf   = 1'b1;
          default: next_work = work_reg;
        endcase
      end
    end
  end

  // Sequencing of the two-byte and two-cycle instructions.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state    <= NAP_EXEC;
      imm_fn   <= FN_ADC;
      busy     <= 1'b0;
      rom_rd   <= 1'b0;
      rom_addr <= '0;
    end else if (ce) begin
      unique case (state)
        NAP_EXEC: begin
          if (go && instr_byte == OP_TABLE_FETCH) begin
            state    <= NAP_TABLE;
            busy     <= 1'b1;
            rom_rd   <= 1'b1;
            rom_addr <= {current_page, work_reg, mem_val};
          end else if (go && instr_byte[7:3] == {GRP_IMM_ALU, 1'b0}) begin
            state  <= NAP_IMM;
            imm_fn <= instr_byte[2:0];
          end
        end
        NAP_IMM: begin
          if (instr_valid) begin
            state <= NAP_EXEC;
          end
        end
        NAP_TABLE: begin
          state  <= NAP_EXEC;
          busy   <= 1'b0;
          rom_rd <= 1'b0;
        end
      endcase
    end
  end

  // Accumulator and carry; the table byte lands here in the second cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      work_reg   <= RST_NIBBLE;
      carry_flag <= 1'b0;
      temp_latch <= RST_NIBBLE;
    end else if (ce) begin
      carry_flag <= next_cf;
      if (state == NAP_TABLE) begin
        work_reg   <= rom_data[7:4];
        temp_latch <= rom_data[3:0];
      end else begin
        work_reg <= next_work;
      end
    end
  end

  // Pointers and the registered RAM write port.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      data_pointer  <= '0;
      saved_pointer <= '0;
      ram_wr        <= '0;
    end else if (ce) begin
      data_pointer  <= next_dp;
      saved_pointer <= next_saved;
      ram_wr.we     <= next_mem_we;
      ram_wr.addr   <= data_pointer;
      ram_wr.data   <= next_mem_data;
    end
  end

  // Status side effects. The clears are pulses so that a wake event landing
  // in the same cycle is kept by the owning logic, which lets the set win.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wake_cause_clr    <= 1'b0;
      half_sec_clr      <= 1'b0;
      timer_wake_enable <= RST_WAKE_EN;
    end else if (ce) begin
      wake_cause_clr <= go && (instr_byte == OP_HALT_CAUSE);
      half_sec_clr   <= go && (instr_byte == OP_HALF_SEC);
      if (go && instr_byte == OP_CLR_WAKE) begin
        timer_wake_enable <= 1'b0;
      end else if (go && instr_byte == OP_SET_WAKE) begin
        timer_wake_enable <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  shift_right_a: assert property (go && instr_byte[7:1] == OP_SHR0[7:1] |=>
    work_reg == {$past(instr_byte[0]), $past(work_reg[3:1])})
    else $error("right shift result wrong");
  shift_left_a: assert property (go && instr_byte[7:1] == OP_SHL0[7:1] |=>
    work_reg == {$past(work_reg[2:0]), $past(instr_byte[0])})
    else $error("left shift result wrong");
  mem_inc_a: assert property (go && instr_byte == OP_MEM_INC |=>
    work_reg == 4'($past(mem_val) + 4'h1) && ram_wr.we
    && ram_wr.data == work_reg && ram_wr.addr == $past(data_pointer))
    else $error("memory increment wrong");
  mem_dec_a: assert property (go && instr_byte == OP_MEM_DEC |=>
    work_reg == 4'($past(mem_val) - 4'h1) && ram_wr.we && ram_wr.data == work_reg)
    else $error("memory decrement wrong");
  table_fetch_a: assert property (go && instr_byte == OP_TABLE_FETCH && ce |=>
    rom_rd && busy && rom_addr == {$past(current_page), $past(work_reg),
    $past(mem_val)} ##1 !busy && work_reg == $past(rom_data[7:4])
    && temp_latch == $past(rom_data[3:0]))
    else $error("table fetch wrong");
  store_temp_a: assert property (go && instr_byte == OP_STORE_TEMP |=>
    ram_wr.we && ram_wr.data == $past(temp_latch) && work_reg == $past(work_reg))
    else $error("temp store wrong");
  add_carry_a: assert property (go && instr_byte[7:3] == 5'h10
    && instr_byte[2:0] == FN_ADC |=> {carry_flag, work_reg} ==
    5'({1'b0, $past(work_reg)} + {1'b0, $past(mem_val)} + 5'($past(carry_flag))))
    else $error("add with carry wrong");
  write_back_a: assert property (go && instr_byte[7:4] == GRP_MEM_ALU |=>
    ram_wr.we == $past(instr_byte[WRITE_BACK_BIT]) && ram_wr.data == work_reg)
    else $error("write back wrong");
  sub_borrow_a: assert property (go && instr_byte[7:3] == 5'h10
    && instr_byte[2:0] == FN_SBC |=> work_reg ==
    4'($past(work_reg) - $past(mem_val) - 4'($past(carry_flag))))
    else $error("subtract with borrow wrong");
  plain_sub_a: assert property (go && instr_byte[7:3] == 5'h10
    && instr_byte[2:0] == FN_SUB |=> carry_flag ==
    ($past(work_reg) >= $past(mem_val)))
    else $error("subtract carry wrong");
  keep_carry_a: assert property (go && instr_byte[7:4] == GRP_MEM_ALU
    && instr_byte[2] && instr_byte[2:0] != FN_SUB |=> $stable(carry_flag))
    else $error("carry changed by keep-carry or logic op");
  imm_add_a: assert property (ce && instr_valid && state == NAP_IMM
    && imm_fn == FN_ADC |=> {carry_flag, work_reg} == 5'({1'b0, $past(work_reg)}
    + {1'b0, $past(instr_byte[3:0])} + 5'($past(carry_flag))))
    else $error("immediate add wrong");
  imm_sub_a: assert property (ce && instr_valid && state == NAP_IMM
    && imm_fn == FN_SUB |=> work_reg == 4'($past(work_reg) - $past(instr_byte[3:0])))
    else $error("immediate subtract wrong");
  imm_logic_a: assert property (ce && instr_valid && state == NAP_IMM
    && imm_fn == FN_AND |=> work_reg == ($past(work_reg) & $past(instr_byte[3:0]))
    && $stable(carry_flag))
    else $error("immediate logic wrong");
  get_pointer_a: assert property (go && instr_byte == OP_GET_HIGH |=>
    work_reg == $past(data_pointer.high))
    else $error("pointer read wrong");
  swap_pointer_a: assert property (go && instr_byte == OP_SWAP_LOW |=>
    data_pointer.low == $past(saved_pointer.low)
    && saved_pointer.low == $past(data_pointer.low))
    else $error("pointer swap wrong");
  step_pointer_a: assert property (go && instr_byte == OP_STEP_UP_L |=>
    data_pointer.low == 4'($past(data_pointer.low) + 4'h1) && $stable(data_pointer.high))
    else $error("pointer step wrong");
  load_pointer_a: assert property (go && instr_byte[7:4] == GRP_LOAD_HIGH |=>
    data_pointer.high == $past(instr_byte[3:0]))
    else $error("pointer load wrong");
  halt_cause_a: assert property (go && instr_byte == OP_HALT_CAUSE |=>
    wake_cause_clr && work_reg == $past(wake_cause_status))
    else $error("halt cause read wrong");
  half_sec_a: assert property (go && instr_byte == OP_HALF_SEC |=>
    half_sec_clr && work_reg == $past(half_second_status))
    else $error("half-second read wrong");
  wake_off_a: assert property (go && instr_byte == OP_CLR_WAKE |=>
    !timer_wake_enable)
    else $error("timer wake not cleared");

  imm_xor_a: assert property (imm_go && imm_fn == FN_XOR |=>
    work_reg == ($past(work_reg) ^ $past(instr_byte[3:0]))
    && $stable(carry_flag))
    else $error("immediate exclusive or wrong");
  imm_or_a: assert property (imm_go && imm_fn == FN_OR |=>
    work_reg == ($past(work_reg) | $past(instr_byte[3:0]))
    && $stable(carry_flag))
    else $error("immediate or wrong");
  imm_borrow_a: assert property (imm_go && imm_fn == FN_SBC |=>
    carry_flag == (5'($past(work_reg)) >= 5'($past(instr_byte[3:0]))
    + 5'($past(carry_flag))))
    else $error("immediate borrow carry wrong");
  imm_keep_a: assert property (imm_go && imm_fn == FN_ADN |=>
    work_reg == 4'($past(work_reg) + $past(instr_byte[3:0]))
    && $stable(carry_flag))
    else $error("immediate keep-carry add wrong");
  sub_carry_a: assert property (go && instr_byte[7:3] == 5'h10
    && instr_byte[2:0] == FN_SBC |=> carry_flag ==
    (5'($past(work_reg)) >= 5'($past(mem_val)) + 5'($past(carry_flag))))
    else $error("subtract with borrow carry wrong");
  add_plain_a: assert property (go && instr_byte[7:4] == GRP_MEM_ALU
    && instr_byte[2:0] == FN_ADD |=> {carry_flag, work_reg} ==
    5'({1'b0, $past(work_reg)} + {1'b0, $past(mem_val)}))
    else $error("plain add wrong");
  mem_xor_a: assert property (go && instr_byte[7:4] == GRP_MEM_ALU
    && instr_byte[2:0] == FN_XOR |=> work_reg ==
    ($past(work_reg) ^ $past(mem_val)))
    else $error("memory exclusive or wrong");
  put_pointer_a: assert property (go && instr_byte == OP_PUT_LOW |=>
    data_pointer.low == $past(work_reg) && $stable(data_pointer.high))
    else $error("pointer store wrong");
  swap_high_a: assert property (go && instr_byte == OP_SWAP_HIGH |=>
    data_pointer.high == $past(saved_pointer.high)
    && saved_pointer.high == $past(data_pointer.high))
    else $error("high pointer swap wrong");
  step_down_a: assert property (go && instr_byte == OP_STEP_DN_H |=>
    data_pointer.high == 4'($past(data_pointer.high) - 4'h1)
    && $stable(data_pointer.low))
    else $error("pointer step down wrong");
  load_low_a: assert property (go && instr_byte[7:4] == GRP_LOAD_LOW
    |=> data_pointer.low == $past(instr_byte[3:0])
    && $stable(data_pointer.high))
    else $error("low pointer load wrong");
  dec_addr_a: assert property (go && instr_byte == OP_MEM_DEC |=>
    ram_wr.addr == $past(data_pointer))
    else $error("memory decrement address wrong");
  store_addr_a: assert property (go && instr_byte == OP_STORE_TEMP |=>
    ram_wr.addr == $past(data_pointer))
    else $error("temp store address wrong");
  table_busy_a: assert property (busy && ce |=> !busy && !ram_wr.we)
    else $error("table fetch busy too long");
  wake_hold_a: assert property (!timer_wake_enable
    && !(go && instr_byte == OP_SET_WAKE) |=> !timer_wake_enable)
    else $error("timer wake enable rose on its own");

  table_run_c: cover property (go && instr_byte == OP_TABLE_FETCH ##2 go);
  imm_run_c:   cover property (go && instr_byte[7:4] == GRP_IMM_ALU ##1 imm_go);
  forward_c:   cover property (ram_wr.we && ram_wr.addr == data_pointer && go);
  freeze_c:    cover property (!ce && ram_wr.we);

endmodule // nap_datapath
`default_nettype wire

// ### rtl/nap_pkg.sv
// Constants, opcodes and carrier types of the nibble ALU and pointer datapath.
// Assumes a sequencer on the same clock that presents instruction bytes.
package nap_pkg;

  localparam int PAGE_W = 3;
  localparam int ROM_AW = 11;

  localparam logic [7:0] OP_TABLE_FETCH = 8'h01;
  localparam logic [7:0] OP_CLR_WAKE    = 8'h06;
  localparam logic [7:0] OP_SET_WAKE    = 8'h07;
  localparam logic [7:0] OP_STORE_TEMP  = 8'h12;
  localparam logic [7:0] OP_SHR0        = 8'h18;
  localparam logic [7:0] OP_SHR1        = 8'h19;
  localparam logic [7:0] OP_SHL0        = 8'h1a;
  localparam logic [7:0] OP_SHL1        = 8'h1b;
  localparam logic [7:0] OP_PUT_LOW     = 8'h1c;
  localparam logic [7:0] OP_PUT_HIGH    = 8'h1d;
  localparam logic [7:0] OP_SWAP_LOW    = 8'h1e;
  localparam logic [7:0] OP_SWAP_HIGH   = 8'h1f;
  localparam logic [7:0] OP_MEM_INC     = 8'h98;
  localparam logic [7:0] OP_MEM_DEC     = 8'h99;
  localparam logic [7:0] OP_STEP_UP_L   = 8'h9a;
  localparam logic [7:0] OP_STEP_DN_L   = 8'h9b;
  localparam logic [7:0] OP_STEP_UP_H   = 8'h9c;
  localparam logic [7:0] OP_STEP_DN_H   = 8'h9d;
  localparam logic [7:0] OP_HALT_CAUSE  = 8'hab;
  localparam logic [7:0] OP_HALF_SEC    = 8'hac;
  localparam logic [7:0] OP_CLR_CARRY   = 8'hf0;
  localparam logic [7:0] OP_SET_CARRY   = 8'hf1;
  localparam logic [7:0] OP_GET_LOW     = 8'hfd;
  localparam logic [7:0] OP_GET_HIGH    = 8'hfe;

  localparam logic [3:0] GRP_MEM_ALU    = 4'h8;
  localparam logic [3:0] GRP_IMM_ALU    = 4'h9;
  localparam logic [3:0] GRP_LOAD_LOW   = 4'hb;
  localparam logic [3:0] GRP_LOAD_HIGH  = 4'hc;
  localparam int         WRITE_BACK_BIT = 3;

  localparam logic [2:0] FN_ADC = 3'h0;
  localparam logic [2:0] FN_SBC = 3'h1;
  localparam logic [2:0] FN_ADD = 3'h2;
  localparam logic [2:0] FN_SUB = 3'h3;
  localparam logic [2:0] FN_ADN = 3'h4;
  localparam logic [2:0] FN_AND = 3'h5;
  localparam logic [2:0] FN_XOR = 3'h6;
  localparam logic [2:0] FN_OR  = 3'h7;

  localparam logic [3:0] RST_NIBBLE   = 4'h0;
  localparam logic       RST_WAKE_EN  = 1'b0;
  localparam int         HALF_SEC_BIT = 0;

  typedef enum logic [2:0] {
    NAP_EXEC  = 3'b001,
    NAP_IMM   = 3'b010,
    NAP_TABLE = 3'b100
  } nap_state_t;

  typedef struct packed {
    logic [3:0] high;
    logic [3:0] low;
  } nap_ptr_t;

  typedef struct packed {
    logic       we;
    nap_ptr_t   addr;
    logic [3:0] data;
  } nap_ram_wr_t;

  typedef struct packed {
    logic       upd;
    logic       cf;
    logic [3:0] val;
  } nap_alu_t;

endpackage

// ### verification/nap_mem_model.sv
// Behavioural program ROM and data RAM on the far side of the datapath.
// Assumes RAM is read at data_pointer and written when ram_wr.we is high.
`timescale 1ns/1ps
`default_nettype none
module nap_mem_model
  import nap_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Program ROM
  input  wire logic              rom_rd,
  input  wire logic [ROM_AW-1:0] rom_addr,
  output logic [7:0]             rom_data,
  // Data RAM
  input  wire nap_ptr_t          data_pointer,
  input  wire nap_ram_wr_t       ram_wr,
  output logic [3:0]             ram_rdata
);
  logic [3:0] ram [256];
  logic [7:0] junk;
  initial begin
    for (int i = 0; i < 256; i++) ram[i] = i[3:0] ^ i[7:4];
    junk = 8'h5a;
  end
  // Outside a fetch the ROM bus toggles, so a late sample never looks valid.
  always @(posedge sys_clk) begin
    junk <= ~junk;
    if (ram_wr.we) ram[ram_wr.addr] <= ram_wr.data;
  end
  always_comb begin
    rom_data = {rom_addr[3:0] ^ rom_addr[7:4],
                rom_addr[7:4] + {1'b0, rom_addr[10:8]}};
    if (!rom_rd) rom_data = junk;
    ram_rdata = ram[data_pointer];
  end
endmodule // nap_mem_model
`default_nettype wire

// ### verification/nibble_alu_pointer_datapath_test.sv
// Self-checking bench for the nibble datapath with a shadow state model.
// Assumes the ROM and RAM behavioural model in nap_mem_model.
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_pointer_datapath_test;
  import nap_pkg::*;
  logic sys_clk, rst_b, ce, instr_valid, busy, rom_rd, carry_flag;
  logic wake_cause_clr, half_sec_clr, timer_wake_enable;
  logic [7:0] instr_byte, rom_data;
  logic [PAGE_W-1:0] current_page;
  logic [ROM_AW-1:0] rom_addr;
  logic [3:0] wake_cause_status, half_second_status, ram_rdata;
  logic [3:0] work_reg, temp_latch;
  nap_ptr_t data_pointer, saved_pointer;
  nap_ram_wr_t ram_wr;
  int num_errors, total_checks;
  logic [3:0] ac, pointer_low_nibble, pointer_high_nibble, swap_pointer_low, swap_pointer_high, tl, xwd;
  logic [3:0] smem [256];
  logic [7:0] xwa;
  logic cf, wen, xwe, xwc, xhc;
  logic [7:0] ops [] = '{8'hb7, 8'hca, 8'h1e, 8'h1f, 8'hbf, 8'h9a, 8'h9a,
    8'h9b, 8'h9b, 8'h9c, 8'h9d, 8'h9d, 8'hfd, 8'h1e, 8'hfe, 8'h1c, 8'h1d,
    8'h18, 8'h19, 8'h1a, 8'h1b, 8'h19, 8'h1b, 8'hb5, 8'h98, 8'h99, 8'hc0,
    8'hb0, 8'h99, 8'hab, 8'hac, 8'h07, 8'h06, 8'h07, 8'hf1, 8'hf0};

  nap_datapath uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
    .instr_valid(instr_valid), .instr_byte(instr_byte), .busy(busy),
    .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_data(rom_data),
    .current_page(current_page), .data_pointer(data_pointer),
    .ram_wr(ram_wr), .ram_rdata(ram_rdata),
    .wake_cause_status(wake_cause_status),
    .half_second_status(half_second_status),
    .wake_cause_clr(wake_cause_clr), .half_sec_clr(half_sec_clr),
    .timer_wake_enable(timer_wake_enable), .work_reg(work_reg),
    .carry_flag(carry_flag), .temp_latch(temp_latch),
    .saved_pointer(saved_pointer));
  nap_mem_model mem (
    .sys_clk(sys_clk), .rom_rd(rom_rd), .rom_addr(rom_addr),
    .rom_data(rom_data), .data_pointer(data_pointer), .ram_wr(ram_wr),
    .ram_rdata(ram_rdata));

  always #20 sys_clk = ~sys_clk;

  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_state;
    check("work_reg", 12'(work_reg), 12'(ac));
    check("carry", 12'(carry_flag), 12'(cf));
    check("pointer", 12'(data_pointer), {4'h0, pointer_high_nibble, pointer_low_nibble});
    check("saved", 12'(saved_pointer), {4'h0, swap_pointer_high, swap_pointer_low});
    check("temp", 12'(temp_latch), 12'(tl));
    check("wake_en", 12'(timer_wake_enable), 12'(wen));
    check("busy", 12'(busy), 12'h0);
    check("wake_clr", 12'(wake_cause_clr), 12'(xwc));
    check("half_clr", 12'(half_sec_clr), 12'(xhc));
    check("ram_we", 12'(ram_wr.we), 12'(xwe));
    if (xwe) check("ram_wr", {ram_wr.addr, ram_wr.data}, {xwa, xwd});
  endtask

  task automatic model(logic [7:0] op, logic [3:0] x);
    logic [4:0] s;
    logic [3:0] m;
    logic [3:0] b;
    m = smem[{pointer_high_nibble, pointer_low_nibble}];
    b = op[4] ? x : m;
    xwa = {pointer_high_nibble, pointer_low_nibble};
    xwc = op == 8'hab;
    xhc = op == 8'hac;
    if (op[7:4] == 4'h8 || op[7:3] == 5'b10010) begin
      case (op[2:0])
        3'h0: s = {1'b0, ac} + b + cf;
        3'h1: s = {1'b0, ac} - b - cf;
        3'h3: s = {1'b0, ac} + {1'b0, ~b} + 5'h1;
        3'h5: s = {1'b0, ac & b};
        3'h6: s = {1'b0, ac ^ b};
        3'h7: s = {1'b0, ac | b};
        default: s = {1'b0, ac} + b;
      endcase
      ac = s[3:0];
      if (op[2:0] < 3'h4) cf = op[2:0] == 3'h1 ? ~s[4] : s[4];
    end else begin
      case (op)
        8'h18, 8'h19: ac = {op[0], ac[3:1]};
        8'h1a, 8'h1b: ac = {ac[2:0], op[0]};
        8'h98: ac = m + 4'h1;
        8'h99: ac = m - 4'h1;
        8'h1c: pointer_low_nibble = ac;
        8'h1d: pointer_high_nibble = ac;
        8'hfd: ac = pointer_low_nibble;
        8'hfe: ac = pointer_high_nibble;
        8'h1e: {pointer_low_nibble, swap_pointer_low} = {swap_pointer_low, pointer_low_nibble};
        8'h1f: {pointer_high_nibble, swap_pointer_high} = {swap_pointer_high, pointer_high_nibble};
        8'h9a: pointer_low_nibble = pointer_low_nibble + 4'h1;
        8'h9b: pointer_low_nibble = pointer_low_nibble - 4'h1;
        8'h9c: pointer_high_nibble = pointer_high_nibble + 4'h1;
        8'h9d: pointer_high_nibble = pointer_high_nibble - 4'h1;
        8'hab: ac = wake_cause_status;
        8'hac: ac = half_second_status;
        8'h06: wen = 1'b0;
        8'h07: wen = 1'b1;
        8'hf0: cf = 1'b0;
        8'hf1: cf = 1'b1;
        default: begin
          if (op[7:4] == 4'hb) pointer_low_nibble = op[3:0];
          if (op[7:4] == 4'hc) pointer_high_nibble = op[3:0];
        end
      endcase
    end
    xwe = op[7:3] == 5'b10001 || op == 8'h98 || op == 8'h99 || op == 8'h12;
    xwd = op == 8'h12 ? tl : ac;
    if (xwe) smem[xwa] = xwd;
  endtask

  task automatic send(logic [7:0] b);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_byte <= b;
  endtask

  task automatic finish_op;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    check_state();
  endtask

  // The operand byte carries junk in its upper nibble, which must be ignored.
  task automatic exec(logic [7:0] op, logic [3:0] x);
    model(op, x);
    send(op);
    if (op[7:3] == 5'b10010) send({4'ha, x});
    finish_op();
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    instr_valid = 1'b0;
    instr_byte = 8'h00;
    current_page = 3'h5;
    wake_cause_status = 4'h9;
    half_second_status = 4'h6;
    num_errors = 0;
    total_checks = 0;
    {ac, pointer_low_nibble, pointer_high_nibble, swap_pointer_low, swap_pointer_high, tl, cf, wen, xwe, xwc, xhc} = '0;
    for (int i = 0; i < 256; i++) smem[i] = i[3:0] ^ i[7:4];
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    check_state();
    $display("reset test done");
    foreach (ops[i]) exec(ops[i], 4'h0);
    model(8'h98, 4'h0);
    model(8'h98, 4'h0);
    send(8'h98);
    send(8'h98);
    finish_op();
    $display("pointer shift status test done");
    for (int i = 0; i < 16; i += 5) begin
      for (int f = 0; f < 16; f++) begin
        exec(f[1] ^ i[0] ? 8'hf1 : 8'hf0, 4'h0);
        exec(8'hc0 | 8'(i), 4'h0);
        exec(8'hfe, 4'h0);
        exec(8'hb0 | 8'(f), 4'h0);
        exec(8'h80 | 8'(f), 4'h0);
        exec(f[0] ? 8'hf1 : 8'hf0, 4'h0);
        exec(8'h90 | 8'(f[2:0]), 4'(i + f));
      end
    end
    $display("alu test done");
    send(8'h01);
    send(8'h98);
    #1;
    check("rom_rd", 12'(rom_rd), 12'h1);
    check("busy_fetch", 12'(busy), 12'h1);
    check("rom_addr", 12'(rom_addr), {1'b0, current_page, ac, smem[{pointer_high_nibble, pointer_low_nibble}]});
    tl = ac + {1'b0, current_page};
    ac = ac ^ smem[{pointer_high_nibble, pointer_low_nibble}];
    {xwe, xwc, xhc} = '0;
    finish_op();
    exec(8'h12, 4'h0);
    $display("table test done");
    model(8'h98, 4'h0);
    send(8'h98);
    @(posedge sys_clk);
    ce <= 1'b0;
    send(8'h98);
    finish_op();
    @(posedge sys_clk);
    ce <= 1'b1;
    $display("clock enable test done");
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    {ac, pointer_low_nibble, pointer_high_nibble, swap_pointer_low, swap_pointer_high, tl, cf, wen, xwe, xwc, xhc} = '0;
    #1;
    check_state();
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule // nibble_alu_pointer_datapath_test
`default_nettype wire
